/* logic/aas_top.sv */
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "aas_consts.svh"
// Behaviour
// - nonzero acquisition: sample, then convert automatically
// - acquisition codes: 0,2,4,6,8,12,16,20 periods
// - zero acquisition: start flag converts at once on the divider clock
// - acquisition select resets to zero
// - completion: clear start, flag done, resample
// - completion loads result high/low pair
// - no status for acquisition end
// - conversion lasts eleven bit periods
// - clock select picks divider or rc
// - rc manual start delayed one instruction
// - conversion start disconnects holding capacitor
// - software clear aborts, result unchanged
// - two-period wait then resample
// - no qualification by channel or direction
// - output pin converts driven digital level
// - analog pins read zero
// - fuse chooses port config reset value
// - fuse 1 gives 0000, 0 gives 0111
// - reset turns converter off, aborts
module aas_top (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        portb_analog_reset_fuse,
    input  wire logic        rc_clk_pin,
    input  wire logic        cmp_pin,
    input  wire logic [12:0] port_pin_in,
    input  wire logic [12:0] pin_direction_bits,
    output logic             sample_en,
    output logic [3:0]       channel_select,
    output logic             convert_digital_level,
    output logic [9:0]       dac_code,
    output logic             conversion_complete_irq_flag
);
    // ==========================================
    // declarations
    aas_pkg::aas_state_t  st_reg;
    aas_pkg::aas_timing_t tim_reg;
    logic        converter_on_reg;
    logic        go_reg;
    logic [3:0]  port_config_bits_reg;
    logic [1:0]  res_hi_reg;
    logic [7:0]  res_lo_reg;
    logic [4:0]  cnt_reg;
    logic [1:0]  init_reg;
    logic [1:0]  fuse_sync_reg;
    logic [1:0]  cmp_sync_reg;
    logic [12:0] pin_sync1_reg;
    logic [12:0] pin_sync2_reg;
    logic [12:0] analog_mask;
    logic [3:0]  analog_cnt;
    logic        wr;
    logic        wr_ctrl;
    logic        sw_abort;
    logic        conv_start;
    logic        tad_tick;
    logic        tad_run;
    logic        sar_done;
    logic [9:0]  sar_result;
    logic        mapped;
    logic [31:0] rd_next;

    // ==========================================
    // input synchronisers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fuse_sync_reg <= 2'h0;
            cmp_sync_reg  <= 2'h0;
            pin_sync1_reg <= 13'h0000;
            pin_sync2_reg <= 13'h0000;
        end else begin
            fuse_sync_reg <= {fuse_sync_reg[0], portb_analog_reset_fuse};
            cmp_sync_reg  <= {cmp_sync_reg[0], cmp_pin};
            pin_sync1_reg <= port_pin_in;
            pin_sync2_reg <= pin_sync1_reg;
        end
    end

    // ==========================================
    // apb slave: zero wait, read data latched in setup
    assign wr      = psel & penable & pwrite;
    assign wr_ctrl = wr && paddr == `AAS_OFF_CTRL;
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~mapped;

    always_comb begin
        mapped  = 1'b1;
        rd_next = 32'h0000_0000;
        case (paddr)
            `AAS_OFF_CTRL: begin
                rd_next = {26'h0, channel_select, go_reg, converter_on_reg};
            end
            `AAS_OFF_TIMING: begin
                rd_next = {26'h0, tim_reg};
            end
            `AAS_OFF_PINCFG: begin
                rd_next = {28'h0, port_config_bits_reg};
            end
            `AAS_OFF_RES_HI: begin
                rd_next = {30'h0, res_hi_reg};
            end
            `AAS_OFF_RES_LO: begin
                rd_next = {24'h0, res_lo_reg};
            end
            `AAS_OFF_STATUS: begin
                rd_next = {31'h0, conversion_complete_irq_flag};
            end
            `AAS_OFF_PORT: begin
                rd_next = {19'h0, pin_sync2_reg & ~analog_mask};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_next;
        end
    end

    // ==========================================
    // analog pin map: 0..2 all 13 analog, then one fewer per code
    assign analog_cnt = (port_config_bits_reg < 4'h3) ? 4'hd : 4'hf - port_config_bits_reg;
    for (genvar i = 0; i < `AAS_NUM_CH; i++) begin : g_mask
        assign analog_mask[i] = (4'(i) < analog_cnt);
    end

    // ==========================================
    // configuration registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            converter_on_reg <= 1'b0;
            channel_select   <= 4'h0;
            tim_reg          <= {`AAS_ACQ_RESET, `AAS_CLK_RESET};
        end else begin
            if (wr_ctrl) begin
                converter_on_reg <= pwdata[`AAS_CTRL_ON];
                channel_select   <= pwdata[`AAS_CTRL_CH_LSB +: 4];
            end
            if (wr && paddr == `AAS_OFF_TIMING) begin
                tim_reg <= pwdata[5:0];
            end
        end
    end

    // fuse is a strap: caught once its synchroniser has settled
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            init_reg             <= 2'h0;
            port_config_bits_reg <= `AAS_PORT_CONFIG_BITS_FUSE0;
        end else begin
            if (init_reg != 2'h3) begin
                init_reg <= init_reg + 2'h1;
            end
            if (init_reg == 2'h2) begin
                port_config_bits_reg <= fuse_sync_reg[1] ? `AAS_PORT_CONFIG_BITS_FUSE1
                                                         : `AAS_PORT_CONFIG_BITS_FUSE0;
            end else if (wr && paddr == `AAS_OFF_PINCFG) begin
                port_config_bits_reg <= pwdata[3:0];
            end
        end
    end

    // ==========================================
    // start flag: completion clears it, software may abort
    assign sw_abort = wr_ctrl & ~pwdata[`AAS_CTRL_GO] & go_reg;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            go_reg <= 1'b0;
        end else if (sar_done || !converter_on_reg) begin
            go_reg <= 1'b0;
        end else if (wr_ctrl) begin
            go_reg <= pwdata[`AAS_CTRL_GO];
        end
    end

    // done flag: set wins over write-one-to-clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            conversion_complete_irq_flag <= 1'b0;
        end else if (sar_done) begin
            conversion_complete_irq_flag <= 1'b1;
        end else if (wr && paddr == `AAS_OFF_STATUS && pwdata[`AAS_STAT_DONE]) begin
            conversion_complete_irq_flag <= 1'b0;
        end
    end

    // ==========================================
    // sequencer; channel and direction never gate it
    assign conv_start = (st_reg != aas_pkg::ST_CONV) && (st_reg != aas_pkg::ST_WAIT)
                        && go_reg && converter_on_reg
                        && ((st_reg == aas_pkg::ST_SAMPLE && tim_reg.acq == 3'h0
                             && !(tim_reg.clk[1] & tim_reg.clk[0]))
                         || (st_reg == aas_pkg::ST_DELAY && cnt_reg == `AAS_TCY_CLKS - 5'h1)
                         || (st_reg == aas_pkg::ST_ACQ && tad_tick
                             && cnt_reg == aas_pkg::acq_tads(tim_reg.acq) - 5'h1));

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg  <= aas_pkg::ST_SAMPLE;
            cnt_reg <= 5'h00;
        end else if (!converter_on_reg) begin
            st_reg  <= aas_pkg::ST_SAMPLE;
            cnt_reg <= 5'h00;
        end else begin
            case (st_reg)
                aas_pkg::ST_SAMPLE: begin
                    cnt_reg <= 5'h00;
                    if (conv_start) begin
                        st_reg <= aas_pkg::ST_CONV;
                    end else if (go_reg && tim_reg.acq == 3'h0) begin
                        st_reg <= aas_pkg::ST_DELAY;
                    end else if (go_reg) begin
                        st_reg <= aas_pkg::ST_ACQ;
                    end
                end
                aas_pkg::ST_DELAY, aas_pkg::ST_ACQ: begin
                    if (!go_reg) begin
                        st_reg  <= aas_pkg::ST_WAIT;
                        cnt_reg <= 5'h00;
                    end else if (conv_start) begin
                        st_reg  <= aas_pkg::ST_CONV;
                        cnt_reg <= 5'h00;
                    end else if (st_reg == aas_pkg::ST_DELAY || tad_tick) begin
                        cnt_reg <= cnt_reg + 5'h01;
                    end
                end
                aas_pkg::ST_CONV: begin
                    cnt_reg <= 5'h00;
                    if (sar_done || !go_reg) begin
                        st_reg <= aas_pkg::ST_WAIT;
                    end
                end
                aas_pkg::ST_WAIT: begin
                    if (tad_tick && cnt_reg == `AAS_WAIT_TADS - 5'h1) begin
                        st_reg  <= aas_pkg::ST_SAMPLE;
                        cnt_reg <= 5'h00;
                    end else if (tad_tick) begin
                        cnt_reg <= cnt_reg + 5'h01;
                    end
                end
                default: begin
                    st_reg <= aas_pkg::ST_SAMPLE;
                end
            endcase
        end
    end

    // capacitor follows the pin only while sampling
    assign sample_en = converter_on_reg && (st_reg == aas_pkg::ST_SAMPLE
                       || st_reg == aas_pkg::ST_DELAY
                       || st_reg == aas_pkg::ST_ACQ);
    // a pin driven as output feeds its own digital level to the mux
    assign convert_digital_level = ~pin_direction_bits[channel_select];
    assign tad_run = st_reg == aas_pkg::ST_ACQ || st_reg == aas_pkg::ST_CONV
                     || st_reg == aas_pkg::ST_WAIT;

    // ==========================================
    // bit clock and approximation engine
    aas_tad_gen #(.DIV_W(6)) u_tad (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .run        (tad_run),
        .clk_sel    (tim_reg.clk),
        .rc_clk_pin (rc_clk_pin),
        .tad_tick   (tad_tick)
    );

    aas_sar u_sar (
        .core_clk (core_clk),
        .nrst     (nrst),
        .start    (conv_start),
        .abort    (st_reg == aas_pkg::ST_CONV && !go_reg),
        .tad_tick (tad_tick),
        .cmp_hi   (cmp_sync_reg[1]),
        .code     (dac_code),
        .result   (sar_result),
        .done     (sar_done)
    );

    // result pair: loaded on completion only, else by software
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            res_hi_reg <= 2'h0;
            res_lo_reg <= 8'h00;
        end else if (sar_done) begin
            res_hi_reg <= sar_result[9:8];
            res_lo_reg <= sar_result[7:0];
        end else if (wr && paddr == `AAS_OFF_RES_HI) begin
            res_hi_reg <= pwdata[1:0];
        end else if (wr && paddr == `AAS_OFF_RES_LO) begin
            res_lo_reg <= pwdata[7:0];
        end
    end

    // ==========================================
    // assertions
    logic [3:0] conv_ticks;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            conv_ticks <= 4'h0;
        end else if (st_reg != aas_pkg::ST_CONV) begin
            conv_ticks <= 4'h0;
        end else if (tad_tick) begin
            conv_ticks <= conv_ticks + 4'h1;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_manual_direct: assert property (conv_start && st_reg == aas_pkg::ST_SAMPLE
        |=> st_reg == aas_pkg::ST_CONV && !sample_en)
        else $error("manual start did not convert at once");
    a_auto_acq: assert property (st_reg == aas_pkg::ST_SAMPLE && go_reg && converter_on_reg
        && tim_reg.acq != 3'h0 |=> st_reg == aas_pkg::ST_ACQ && sample_en)
        else $error("programmed acquisition not entered");
    a_rc_delay: assert property ($rose(st_reg == aas_pkg::ST_DELAY) && converter_on_reg
        |-> (st_reg == aas_pkg::ST_DELAY && go_reg)[*4] ##1 st_reg == aas_pkg::ST_CONV)
        else $error("instruction cycle delay wrong");
    a_conv_len: assert property (sar_done |-> conv_ticks == 4'hb)
        else $error("conversion not eleven bit periods");
    a_done_effects: assert property (sar_done |=> !go_reg && conversion_complete_irq_flag
        && st_reg == aas_pkg::ST_WAIT && {res_hi_reg, res_lo_reg} == $past(sar_result))
        else $error("completion effects missing");
    a_abort_keep: assert property (st_reg == aas_pkg::ST_CONV && !go_reg && converter_on_reg
        |=> st_reg == aas_pkg::ST_WAIT && $stable({res_hi_reg, res_lo_reg})
        && !conversion_complete_irq_flag[*1])
        else $error("abort changed result or flagged");
    a_sw_abort: assert property (sw_abort |=> !go_reg)
        else $error("software clear did not drop start flag");
    a_hold_off: assert property (st_reg == aas_pkg::ST_CONV |-> !sample_en)
        else $error("capacitor connected during conversion");
    a_wait_two: assert property (st_reg == aas_pkg::ST_WAIT && tad_tick && cnt_reg == 5'h1
        && converter_on_reg |=> st_reg == aas_pkg::ST_SAMPLE)
        else $error("post conversion wait wrong");
    a_go_held: assert property (st_reg == aas_pkg::ST_ACQ || st_reg == aas_pkg::ST_CONV
        |-> go_reg || $fell(go_reg))
        else $error("start flag dropped early");
    a_port_zero: assert property (psel && !penable && !pwrite && paddr == `AAS_OFF_PORT
        |=> (prdata[12:0] & analog_mask) == 13'h0000)
        else $error("analog pin read nonzero");

    c_manual: cover property (st_reg == aas_pkg::ST_SAMPLE ##1 st_reg == aas_pkg::ST_CONV);
    c_auto: cover property (st_reg == aas_pkg::ST_ACQ ##1 st_reg == aas_pkg::ST_CONV);
    c_abort: cover property (st_reg == aas_pkg::ST_CONV && !go_reg);
    c_rc_done: cover property (st_reg == aas_pkg::ST_DELAY ##[1:300] sar_done);
endmodule : aas_top

/* logic/aas_consts.svh */
`ifndef AAS_CONSTS_SVH
`define AAS_CONSTS_SVH
// ==========================================
// register byte offsets
`define AAS_OFF_CTRL    8'h00
`define AAS_OFF_TIMING  8'h04
`define AAS_OFF_PINCFG  8'h08
`define AAS_OFF_RES_HI  8'h0c
`define AAS_OFF_RES_LO  8'h10
`define AAS_OFF_STATUS  8'h14
`define AAS_OFF_PORT    8'h18
// ==========================================
// field positions
`define AAS_CTRL_ON     0
`define AAS_CTRL_GO     1
`define AAS_CTRL_CH_LSB 2
`define AAS_TIM_CLK_LSB 0
`define AAS_TIM_ACQ_LSB 3
`define AAS_STAT_DONE   0
// ==========================================
// reset values
`define AAS_ACQ_RESET   3'h0
`define AAS_CLK_RESET   3'h0
`define AAS_PORT_CONFIG_BITS_FUSE1  4'h0
`define AAS_PORT_CONFIG_BITS_FUSE0  4'h7
// ==========================================
// timing and channel counts
`define AAS_CONV_TADS   4'ha
`define AAS_WAIT_TADS   5'h2
`define AAS_TCY_CLKS    5'h4
`define AAS_NUM_CH      13
`endif

/* logic/aas_pkg.sv */
package aas_pkg;
    // ==========================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_SAMPLE,
        ST_DELAY,
        ST_ACQ,
        ST_CONV,
        ST_WAIT
    } aas_state_t;

    // ==========================================
    // timing control fields
    typedef struct packed {
        logic [2:0] acq;
        logic [2:0] clk;
    } aas_timing_t;

    // acquisition length in bit periods, codes ascending
    function automatic logic [4:0] acq_tads(input logic [2:0] code);
        case (code)
            3'h0: acq_tads = 5'h00;
            3'h1: acq_tads = 5'h02;
            3'h2: acq_tads = 5'h04;
            3'h3: acq_tads = 5'h06;
            3'h4: acq_tads = 5'h08;
            3'h5: acq_tads = 5'h0c;
            3'h6: acq_tads = 5'h10;
            default: acq_tads = 5'h14;
        endcase
    endfunction : acq_tads
endpackage : aas_pkg

/* logic/aas_tad_gen.sv */
`timescale 1ns/1ps
module aas_tad_gen #(
    parameter int DIV_W = 6
) (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       run,
    input  wire logic [2:0] clk_sel,
    input  wire logic       rc_clk_pin,
    output logic            tad_tick
);
    // ==========================================
    // checks
    if (DIV_W < 6) begin : g_chk
        $error("aas_tad_gen: DIV_W too small for divide by 64");
    end

    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] lim;
    logic [2:0]       rc_sync_reg;
    logic             use_rc;
    logic             rc_rise;

    // ==========================================
    // rc source: sync then edge detect on second stage
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rc_sync_reg <= 3'h0;
        end else begin
            rc_sync_reg <= {rc_sync_reg[1:0], rc_clk_pin};
        end
    end
    assign rc_rise = rc_sync_reg[1] & ~rc_sync_reg[2];
    assign use_rc  = clk_sel[1] & clk_sel[0];

    // 000:2 100:4 001:8 101:16 010:32 110:64 oscillator periods
    assign lim = DIV_W'((2 << {clk_sel[1:0], clk_sel[2]}) - 1);

    // ==========================================
    // divider restarts whenever the sequencer idles
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_reg <= '0;
        end else if (!run || use_rc || div_reg == lim) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    assign tad_tick = run & (use_rc ? rc_rise : (div_reg == lim));
endmodule : aas_tad_gen

/* logic/aas_sar.sv */
`timescale 1ns/1ps
`include "aas_consts.svh"
module aas_sar (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic       tad_tick,
    input  wire logic       cmp_hi,
    output logic [9:0]      code,
    output logic [9:0]      result,
    output logic            done
);
    logic [3:0] step_reg;
    logic       busy_reg;
    logic [9:0] cur;
    logic [9:0] keep;

    // step 0 sets up, steps 1..10 decide one bit each, msb first
    assign cur  = 10'h200 >> (step_reg - 4'h1);
    assign keep = cmp_hi ? code : (code & ~cur);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            step_reg <= 4'h0;
            busy_reg <= 1'b0;
            code     <= 10'h000;
            result   <= 10'h000;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy_reg <= 1'b0;
            end else if (start) begin
                busy_reg <= 1'b1;
                step_reg <= 4'h0;
                code     <= 10'h000;
            end else if (busy_reg && tad_tick) begin
                step_reg <= step_reg + 4'h1;
                if (step_reg == 4'h0) begin
                    code <= 10'h200;
                end else if (step_reg == `AAS_CONV_TADS) begin
                    code     <= keep;
                    result   <= keep;
                    done     <= 1'b1;
                    busy_reg <= 1'b0;
                end else begin
                    code <= keep | (cur >> 1);
                end
            end
        end
    end
endmodule : aas_sar

/* verification/aas_bench.sv */
`timescale 1ns/1ps
`include "aas_consts.svh"
module adc_acquisition_sequencer_bench;
    // ==========================================
    // signals
    logic        core_clk;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [12:0] pins;
    logic [12:0] dirs;
    logic        sample_en;
    logic        conv_dig;
    logic        irq;
    logic        fuse;
    logic        rc;
    logic [3:0]  chan;
    logic [9:0]  dac;
    logic [31:0] rd;
    logic        err;
    int          failures;
    int          samples_checked;
    int          cycles;
    int          lo;
    int          base;
    int          base0;
    int          n;
    int          divs[6] = '{2, 4, 8, 16, 32, 64};
    int          sels[6] = '{0, 4, 1, 5, 2, 6};
    int          acqs[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

    aas_top uut (
        .core_clk                     (core_clk),
        .nrst                         (nrst),
        .psel                         (psel),
        .penable                      (penable),
        .pwrite                       (pwrite),
        .paddr                        (paddr),
        .pwdata                       (pwdata),
        .prdata                       (prdata),
        .pready                       (pready),
        .pslverr                      (pslverr),
        .portb_analog_reset_fuse      (fuse),
        .rc_clk_pin                   (rc),
        .cmp_pin                      (1'b1),
        .port_pin_in                  (pins),
        .pin_direction_bits           (dirs),
        .sample_en                    (sample_en),
        .channel_select               (chan),
        .convert_digital_level        (conv_dig),
        .dac_code                     (dac),
        .conversion_complete_irq_flag (irq)
    );

    // ==========================================
    // clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        rc <= cycles[2];
        if (cycles == 30000) begin
            failures++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("comparisons %0d, failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test

    // ==========================================
    // compares and bus access
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // tick phase is free, so lengths get a tolerance
    task automatic chk_n(input string nm, input int exp, input int got, input int tol);
        samples_checked++;
        if (got < exp - tol || got > exp + tol) begin
            failures++;
            $display("mismatch %s expected %0d seen %0d", nm, exp, got);
        end
    endtask : chk_n

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // start, then time the capacitor-disconnected span
    task automatic conv(input logic [31:0] ctrl);
        apb(1'b1, `AAS_OFF_CTRL, ctrl);
        base = 0;
        lo = 0;
        while (sample_en === 1'b1 && base < 3000) begin
            @(posedge core_clk);
            base++;
        end
        while (sample_en !== 1'b1 && lo < 3000) begin
            @(posedge core_clk);
            lo++;
        end
    endtask : conv

    // ==========================================
    // main sequence
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fuse = 1'b1;
        pins = 13'h1fff;
        dirs = 13'h1ff7;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (5) @(posedge core_clk);
        apb(1'b0, `AAS_OFF_TIMING, 32'h0);
        chk("timing reset", 32'h0, rd);
        apb(1'b0, `AAS_OFF_PINCFG, 32'h0);
        chk("pincfg reset", 32'h0, rd);
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b1, `AAS_OFF_PINCFG, 32'h7);
        apb(1'b0, `AAS_OFF_PORT, 32'h0);
        chk("port read", 32'h1f00, rd);
        apb(1'b1, `AAS_OFF_CTRL, 32'h0d);
        repeat (10) @(posedge core_clk);
        chk("digital level", 32'h1, {31'h0, conv_dig});
        chk("channel", 32'h3, {28'h0, chan});
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `AAS_OFF_TIMING, sels[i]);
            conv(32'h0f);
            chk_n("conv span", 13 * divs[i], lo, divs[i] + 4);
            apb(1'b0, `AAS_OFF_CTRL, 32'h0);
            chk("go cleared", 32'h0d, rd);
            chk("irq flag", 32'h1, {31'h0, irq});
            apb(1'b1, `AAS_OFF_STATUS, 32'h1);
        end
        apb(1'b0, `AAS_OFF_RES_HI, 32'h0);
        chk("result high", 32'h3, rd);
        apb(1'b0, `AAS_OFF_RES_LO, 32'h0);
        chk("result low", 32'hff, rd);
        chk("dac code", 32'h3ff, {22'h0, dac});
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, `AAS_OFF_TIMING, i << 3);
            conv(32'h0f);
            if (i == 0) base0 = base;
            chk_n("acq span", 2 * acqs[i], base - base0, 3);
        end
        apb(1'b1, `AAS_OFF_RES_HI, 32'h1);
        apb(1'b1, `AAS_OFF_RES_LO, 32'h5a);
        apb(1'b1, `AAS_OFF_STATUS, 32'h1);
        apb(1'b1, `AAS_OFF_TIMING, 32'h3e);
        apb(1'b1, `AAS_OFF_CTRL, 32'h0f);
        apb(1'b0, `AAS_OFF_CTRL, 32'h0);
        chk("go in acq", 32'h0f, rd);
        apb(1'b0, `AAS_OFF_STATUS, 32'h0);
        chk("no acq status", 32'h0, rd);
        chk("capacitor on", 32'h1, {31'h0, sample_en});
        n = 0;
        while (sample_en === 1'b1 && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        chk_n("acq length", 1280, n, 80);
        repeat (100) @(posedge core_clk);
        apb(1'b1, `AAS_OFF_CTRL, 32'h0d);
        n = 0;
        while (sample_en !== 1'b1 && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        chk_n("abort wait", 128, n, 70);
        apb(1'b0, `AAS_OFF_RES_LO, 32'h0);
        chk("kept low", 32'h5a, rd);
        apb(1'b0, `AAS_OFF_RES_HI, 32'h0);
        chk("kept high", 32'h1, rd);
        chk("no irq", 32'h0, {31'h0, irq});
        // rc clock, manual acquisition: one instruction cycle before conversion
        apb(1'b1, `AAS_OFF_TIMING, 32'h03);
        conv(32'h0f);
        chk_n("rc delay", `AAS_TCY_CLKS, base - base0, 0);
        chk_n("rc span", 13 * 8, lo, 12);
        // second reset lands in mid conversion, fuse now low
        apb(1'b1, `AAS_OFF_CTRL, 32'h0f);
        repeat (20) @(posedge core_clk);
        fuse <= 1'b0;
        nrst <= 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk("off after reset", 32'h0, {31'h0, sample_en});
        apb(1'b0, `AAS_OFF_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, `AAS_OFF_PINCFG, 32'h0);
        chk("pincfg fuse low", 32'h7, rd);
        finish_test();
    end
endmodule : adc_acquisition_sequencer_bench
